//--- hdl/bth_term.sv
// Termination handler of a two-port bridge: one transaction entry, the
// target-bus attempt engine, initiator-side answers and error reporting.
// Assumes target-bus pins arrive asynchronously; initiator requests are
// presented by same-clock logic as one-cycle pulses.
//
// Functional notes
// - Delayed transactions are reissued until data moves or an abort ends them.
// - Retried attempts are bounded by a limit, default 2^24, up to 2^32.
// - Delayed write done: first data phase completes, disconnect if more requested.
// - Delayed write retried by target: initiator retried, attempts continue.
// - Delayed write target abort: abort returned, received and signalled flags set.
// - Delayed write limit exhausted: system error if enabled and mask bit 5 clear.
// - Posted write normal: nothing more; retried: same start address reused.
// - Posted write disconnected: new write starts at next undelivered dword.
// - Partly delivered invalidate write finishes with plain memory write command.
// - Posted write target abort: received flag, system error if enabled, flag it.
// - Posted data undelivered at limit: system error if enabled, mask bit 2 clear.
// - Delayed read done: non-prefetch disconnects first phase; prefetch only if short.
// - Delayed read disconnected by target: initiator disconnected only if it wants more.
// - Delayed read retried by target: read issued again.
// - Delayed read target abort: abort returned, received and signalled flags set.
// - Delayed read limit exhausted: system error if enabled and mask bit 5 clear.
// - Delayed write initiators are retried while queueing, pending, full, duplicate, locked.
// - Delayed read initiators retried likewise, also behind posted write or discarding.
// - Posted write retried without buffer room or when an unlocked write meets a lock.
// - A delayed transaction not repeated within master timeout is dropped.
// - Initiators are disconnected only when fewer dwords moved than they requested.
// - Target abort only forwards a real abort and sets signalled-abort on that side.
`timescale 1ns/1ns
`include "bth_defines.svh"

module bth_term import bth_pkg::*; #(
    parameter int MASTER_TIMEOUT = `BTH_MASTER_TIMEOUT,
    parameter logic [31:0] ATTEMPT_LIMIT = `BTH_LIMIT_RESET
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic link_clk,
    input wire logic tgt_devsel_n,
    input wire logic tgt_trdy_n,
    input wire logic tgt_stop_n,
    input wire logic req_valid,
    input wire bth_kind_t req_kind,
    input wire logic [3:0] req_cmd,
    input wire logic [31:0] req_addr,
    input wire logic [7:0] req_dwords,
    input wire logic req_prefetch,
    input wire logic req_locked,
    input wire logic req_primary,
    input wire logic pw_space_ok,
    input wire logic queue_full,
    input wire logic lock_crossing,
    input wire logic tbus_locked,
    input wire logic discarding,
    input wire logic posted_ahead,
    output logic init_resp_valid,
    output bth_resp_t init_resp,
    output logic mst_start,
    output logic [31:0] mst_addr,
    output logic [3:0] mst_cmd,
    output logic [7:0] mst_dwords,
    output logic primary_system_error_out
);

    localparam logic [31:0] TMO_LAST = 32'(MASTER_TIMEOUT - 1);
    localparam logic [4:0] SERR_HOLD = 5'(`BTH_SERR_HOLD_CYC);

    function automatic logic [7:0] bit8(input int b);
        bit8 = 8'h01 << b;
    endfunction

    // ****************************************
    // Target-bus pin synchronisers
    // ****************************************
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic lclk_d;
    wire [3:0] pins_in = {link_clk, tgt_devsel_n, tgt_trdy_n, tgt_stop_n};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1[gi] <= 1'b1;
                    sync2[gi] <= 1'b1;
                end else begin
                    sync1[gi] <= pins_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) lclk_d <= 1'b1;
        else lclk_d <= sync2[3];
    end

    wire link_edge = sync2[3] & ~lclk_d;
    wire devsel = ~sync2[2];
    wire trdy = ~sync2[1];
    wire stop = ~sync2[0];

    // ****************************************
    // Registers and AHB-Lite slave
    // ****************************************
    logic serr_en;
    logic [31:0] attempt_limit;
    logic [7:0] status;
    logic [7:0] event_mask;
    logic [31:0] attempts;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rd_val;
    logic [7:0] stat_set_q;
    logic [7:0] sig_ta_set;

    wire ap_take = hsel & hready & htrans[1];
    wire wr_ctrl = wr_pend & (wr_addr == `BTH_CTRL_OFS);
    wire wr_limit = wr_pend & (wr_addr == `BTH_LIMIT_OFS);
    wire wr_stat = wr_pend & (wr_addr == `BTH_STAT_OFS);
    wire wr_mask = wr_pend & (wr_addr == `BTH_MASK_OFS);
    wire [7:0] stat_clr = wr_stat ? hwdata[7:0] : 8'h00;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (haddr[7:0] == `BTH_CTRL_OFS) begin
            rd_val[`BTH_SERR_EN_BIT] = serr_en;
        end else if (haddr[7:0] == `BTH_LIMIT_OFS) begin
            rd_val = attempt_limit;
        end else if (haddr[7:0] == `BTH_STAT_OFS) begin
            rd_val = {24'h00_0000, status};
        end else if (haddr[7:0] == `BTH_COUNT_OFS) begin
            rd_val = attempts;
        end else if (haddr[7:0] == `BTH_MASK_OFS) begin
            rd_val = {24'h00_0000, event_mask};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= ap_take & hwrite;
            wr_addr <= haddr[7:0];
            if (ap_take & ~hwrite) hrdata <= rd_val;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serr_en <= 1'b0;
            attempt_limit <= ATTEMPT_LIMIT;
            event_mask <= `BTH_MASK_RESET;
            status <= 8'h00;
        end else begin
            if (wr_ctrl) serr_en <= hwdata[`BTH_SERR_EN_BIT];
            if (wr_limit) attempt_limit <= hwdata;
            if (wr_mask) event_mask <= hwdata[7:0];
            // Set wins over a simultaneous write-one-to-clear
            status <= (status & ~stat_clr) | stat_set_q | sig_ta_set;
        end
    end

    // ****************************************
    // Transaction entry and initiator answers
    // ****************************************
    bth_ent_t ent_state;
    bth_kind_t ent_kind;
    logic [3:0] ent_cmd;
    logic [31:0] ent_addr;
    logic [7:0] ent_dwords;
    logic ent_prefetch;
    logic ent_primary;
    logic [7:0] ent_got;
    bth_term_t ent_res;
    logic [31:0] tmo_cnt;

    wire is_pw = req_kind == BTH_PW;
    wire ent_match = (ent_state != E_EMPTY) & (ent_kind != BTH_PW) & (req_kind == ent_kind)
        & (req_addr == ent_addr) & (req_cmd == ent_cmd);
    wire lock_blk = (lock_crossing & ~req_locked) | (~is_pw & tbus_locked & req_locked);
    wire rd_hold = (req_kind == BTH_DR) & (discarding | posted_ahead);
    wire req_release = req_valid & ent_match & (ent_state == E_DONE) & ~rd_hold;
    wire req_queue = req_valid & ~ent_match & (ent_state == E_EMPTY) & ~queue_full
        & ~lock_blk & ~((req_kind == BTH_DR) & discarding) & (~is_pw | pw_space_ok);
    wire want_more = req_dwords > ent_got;
    wire bth_resp_t done_resp = (ent_res == T_TABORT) ? R_ABORT :
        (ent_res == T_MABORT) ? R_NOSEL : want_more ? R_DATA_DISC : R_DATA;
    wire bth_resp_t req_resp = is_pw ? (req_queue ? R_DATA : R_RETRY) :
        req_release ? done_resp : R_RETRY;
    wire tmo_hit = (ent_state == E_DONE) & (tmo_cnt == TMO_LAST);

    // Forwarded abort only, flagged on the initiator's side
    assign sig_ta_set = (req_release & (ent_res == T_TABORT)) ?
        bit8(ent_primary ? `BTH_ST_PRI_SIG_TA : `BTH_ST_SEC_SIG_TA) : 8'h00;

    // ****************************************
    // Target-bus attempt engine
    // ****************************************
    bth_mst_t m_state;
    bth_term_t term_q;
    logic [7:0] phase;
    logic [2:0] dv_wait;
    logic seen_dv;
    logic serr_fire;

    wire single = (ent_kind == BTH_DW) | ((ent_kind == BTH_DR) & ~ent_prefetch);
    wire xfer_now = devsel & trdy;
    wire [7:0] moved = phase + {7'h00, xfer_now};
    wire t_abort = stop & ~devsel;
    wire t_stop = stop & devsel;
    wire no_dv = ~devsel & ~seen_dv & (dv_wait == `BTH_DEVSEL_LAST);
    wire t_full = xfer_now & (single | (moved == ent_dwords));
    wire term_now = t_abort | t_stop | no_dv | t_full;
    wire bth_term_t term_kind = t_abort ? T_TABORT : no_dv ? T_MABORT :
        t_stop ? ((moved == 8'h00) ? T_RETRY : T_DISC) : T_NORMAL;
    wire [31:0] attempts_nx = attempts + 32'h0000_0001;
    // A zero limit wraps at 2^32 attempts
    wire limit_hit = attempts_nx == attempt_limit;
    wire [7:0] left = ent_dwords - phase;
    wire [7:0] rcv_ta = bit8(ent_primary ? `BTH_ST_SEC_RCV_TA : `BTH_ST_PRI_RCV_TA);
    wire pw_serr_ok = serr_en & ~event_mask[`BTH_MASK_PW_BIT];
    wire dly_serr_ok = serr_en & ~event_mask[`BTH_MASK_DLY_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ent_state <= E_EMPTY;
            ent_kind <= BTH_DW;
            ent_cmd <= 4'h0;
            ent_addr <= 32'h0000_0000;
            ent_dwords <= 8'h00;
            ent_prefetch <= 1'b0;
            ent_primary <= 1'b0;
            ent_got <= 8'h00;
            ent_res <= T_NORMAL;
            attempts <= 32'h0000_0000;
            tmo_cnt <= 32'h0000_0000;
            init_resp_valid <= 1'b0;
            init_resp <= R_NONE;
            m_state <= M_IDLE;
            term_q <= T_NORMAL;
            phase <= 8'h00;
            dv_wait <= 3'h0;
            seen_dv <= 1'b0;
            mst_start <= 1'b0;
            mst_addr <= 32'h0000_0000;
            mst_cmd <= 4'h0;
            mst_dwords <= 8'h00;
            serr_fire <= 1'b0;
            stat_set_q <= 8'h00;
        end else begin
            init_resp_valid <= req_valid;
            init_resp <= req_valid ? req_resp : R_NONE;
            mst_start <= 1'b0;
            serr_fire <= 1'b0;
            stat_set_q <= 8'h00;
            if (req_queue) begin
                ent_state <= E_BUSY;
                ent_kind <= req_kind;
                ent_cmd <= req_cmd;
                ent_addr <= req_addr;
                ent_dwords <= req_dwords;
                ent_prefetch <= req_prefetch;
                ent_primary <= req_primary;
                ent_got <= 8'h00;
                attempts <= 32'h0000_0000;
                tmo_cnt <= 32'h0000_0000;
            end else if (req_release | tmo_hit) begin
                ent_state <= E_EMPTY;
            end else if (req_valid & ent_match) begin
                tmo_cnt <= 32'h0000_0000;
            end else if (ent_state == E_DONE) begin
                tmo_cnt <= tmo_cnt + 32'h0000_0001;
            end
            case (m_state)
                M_IDLE: begin
                    if ((ent_state == E_BUSY) & ~req_queue) begin
                        m_state <= M_START;
                        mst_start <= 1'b1;
                        mst_addr <= ent_addr;
                        mst_cmd <= ent_cmd;
                        mst_dwords <= ent_dwords;
                        phase <= 8'h00;
                        dv_wait <= 3'h0;
                        seen_dv <= 1'b0;
                    end
                end
                M_START: begin
                    m_state <= M_DATA;
                end
                M_DATA: begin
                    if (link_edge) begin
                        phase <= moved;
                        seen_dv <= seen_dv | devsel;
                        if (~devsel & ~seen_dv) dv_wait <= dv_wait + 3'h1;
                        if (term_now) begin
                            term_q <= term_kind;
                            m_state <= M_END;
                        end
                    end
                end
                M_END: begin
                    m_state <= M_IDLE;
                    if (term_q == T_TABORT) begin
                        stat_set_q <= rcv_ta;
                        if (ent_kind == BTH_PW) begin
                            ent_state <= E_EMPTY;
                            if (serr_en) begin
                                serr_fire <= 1'b1;
                                stat_set_q <= rcv_ta | bit8(`BTH_ST_PRI_SIG_SERR);
                            end
                        end else begin
                            ent_res <= T_TABORT;
                            ent_state <= E_DONE;
                        end
                    end else if (term_q == T_MABORT) begin
                        ent_res <= T_MABORT;
                        ent_state <= (ent_kind == BTH_PW) ? E_EMPTY : E_DONE;
                    end else if (ent_kind == BTH_PW) begin
                        if ((term_q == T_NORMAL) | (left == 8'h00)) begin
                            ent_state <= E_EMPTY;
                        end else begin
                            ent_addr <= ent_addr + {22'h00_0000, phase, 2'h0};
                            ent_dwords <= left;
                            if ((ent_cmd == `BTH_CMD_MWI) & (phase != 8'h00)) begin
                                ent_cmd <= `BTH_CMD_MW;
                            end
                            attempts <= attempts_nx;
                            if (limit_hit) begin
                                ent_state <= E_EMPTY;
                                if (pw_serr_ok) begin
                                    serr_fire <= 1'b1;
                                    stat_set_q <= bit8(`BTH_ST_PRI_SIG_SERR);
                                end
                            end
                        end
                    end else if (term_q == T_RETRY) begin
                        attempts <= attempts_nx;
                        if (limit_hit) begin
                            ent_state <= E_EMPTY;
                            if (dly_serr_ok) begin
                                serr_fire <= 1'b1;
                                stat_set_q <= bit8(`BTH_ST_PRI_SIG_SERR);
                            end
                        end
                    end else begin
                        ent_res <= T_NORMAL;
                        ent_got <= phase;
                        ent_state <= E_DONE;
                    end
                end
                default: m_state <= M_IDLE;
            endcase
        end
    end

    // ****************************************
    // System error output
    // ****************************************
    // Held one link period so a slow sampler cannot miss it
    logic [4:0] serr_cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serr_cnt <= 5'h00;
            primary_system_error_out <= 1'b0;
        end else if (serr_fire) begin
            serr_cnt <= SERR_HOLD;
            primary_system_error_out <= 1'b1;
        end else begin
            if (serr_cnt != 5'h00) serr_cnt <= serr_cnt - 5'h01;
            primary_system_error_out <= serr_cnt > 5'h01;
        end
    end

endmodule

//--- hdl/bth_defines.svh
// Constants for the bridge termination handler: register offsets,
// field positions, reset values and timing counts.
// Assumes a 100 MHz system clock and AHB-Lite word access.
`ifndef BTH_DEFINES_SVH
`define BTH_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define BTH_CTRL_OFS 8'h00
`define BTH_LIMIT_OFS 8'h04
`define BTH_STAT_OFS 8'h08
`define BTH_COUNT_OFS 8'h0c
`define BTH_MASK_OFS 8'h64

// ****************************************
// Field positions
// ****************************************
`define BTH_SERR_EN_BIT 8
`define BTH_MASK_PW_BIT 2
`define BTH_MASK_DLY_BIT 5
`define BTH_ST_PRI_SIG_TA 0
`define BTH_ST_PRI_RCV_TA 1
`define BTH_ST_SEC_SIG_TA 2
`define BTH_ST_SEC_RCV_TA 3
`define BTH_ST_PRI_SIG_SERR 4

// ****************************************
// Reset values and codes
// ****************************************
`define BTH_LIMIT_RESET 32'h0100_0000
`define BTH_MASK_RESET 8'h00
`define BTH_CMD_MW 4'h7
`define BTH_CMD_MWI 4'hf

// ****************************************
// Timing
// ****************************************
`define BTH_DEVSEL_LAST 3'h4
`define BTH_CLK_NS 10
`define BTH_SERR_HOLD_NS 160
`define BTH_SERR_HOLD_CYC ((`BTH_SERR_HOLD_NS + `BTH_CLK_NS - 1) / `BTH_CLK_NS)
`define BTH_MASTER_TIMEOUT 32768

`endif

//--- hdl/bth_pkg.sv
// Types shared by the bridge termination handler.
// Assumes bth_defines.svh supplies the numeric constants.
package bth_pkg;
    typedef enum logic [1:0] {BTH_DW = 2'h0, BTH_PW = 2'h1, BTH_DR = 2'h2} bth_kind_t;
    typedef enum logic [1:0] {M_IDLE = 2'h0, M_START = 2'h1, M_DATA = 2'h3, M_END = 2'h2} bth_mst_t;
    typedef enum logic [1:0] {E_EMPTY = 2'h0, E_BUSY = 2'h1, E_DONE = 2'h3} bth_ent_t;
    typedef enum logic [2:0] {
        T_NORMAL = 3'h0, T_RETRY = 3'h1, T_DISC = 3'h2, T_TABORT = 3'h3, T_MABORT = 3'h4
    } bth_term_t;
    typedef enum logic [2:0] {
        R_NONE = 3'h0, R_RETRY = 3'h1, R_DATA = 3'h2, R_DATA_DISC = 3'h3,
        R_ABORT = 3'h4, R_NOSEL = 3'h5
    } bth_resp_t;
endpackage

//--- bench/bth_term_props.sv
// Checker on bth_term ports: answers, refusals, starts, system error.
// Assumes bth_pkg is compiled first; bound to every bth_term.
`timescale 1ns/1ns
module bth_term_props import bth_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req_valid,
    input wire bth_kind_t req_kind,
    input wire logic req_locked,
    input wire logic pw_space_ok,
    input wire logic queue_full,
    input wire logic lock_crossing,
    input wire logic discarding,
    input wire logic init_resp_valid,
    input wire bth_resp_t init_resp,
    input wire logic mst_start,
    input wire logic [31:0] mst_addr,
    input wire logic primary_system_error_out
);
    // ****
    // Properties
    // ****
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_next: assert property (req_valid |=> init_resp_valid)
        else $error("answer missing");
    a_resp_cause: assert property (!req_valid |=> !init_resp_valid)
        else $error("answer without request");
    a_full_retry: assert property (req_valid && queue_full && req_kind != BTH_PW
        |=> init_resp == R_RETRY) else $error("full queue not retried");
    a_pw_room: assert property (req_valid && req_kind == BTH_PW && !pw_space_ok
        |=> init_resp == R_RETRY) else $error("posted without room");
    a_pw_lock: assert property (req_valid && req_kind == BTH_PW
        && lock_crossing && !req_locked |=> init_resp == R_RETRY) else $error("lock pass");
    a_discard_retry: assert property (req_valid && req_kind == BTH_DR
        && discarding |=> init_resp == R_RETRY) else $error("read while discarding");
    a_serr_hold: assert property ($rose(primary_system_error_out)
        |-> primary_system_error_out [*8]) else $error("system error too short");
    a_start_pulse: assert property (mst_start |=> !mst_start)
        else $error("start longer than one cycle");
    a_addr_stands: assert property (!$stable(mst_addr) |-> mst_start)
        else $error("address moved without start");
    // Main scenarios reached
    cover property (init_resp_valid && init_resp == R_ABORT);
    cover property (init_resp_valid && init_resp == R_DATA_DISC);
    cover property ($rose(primary_system_error_out));
endmodule

bind bth_term bth_term_props i_props (.hclk, .hresetn, .req_valid, .req_kind, .req_locked,
    .pw_space_ok, .queue_full, .lock_crossing, .discarding, .init_resp_valid, .init_resp,
    .mst_start, .mst_addr, .primary_system_error_out);

//--- bench/bth_tgt_model.sv
// Far-side target: makes the link clock and answers each attempt.
// Assumes mst_start pulses one hclk wide; pins pulled up when released.
`timescale 1ns/1ns
module bth_tgt_model (
    input wire logic mst_start,
    input wire logic [1:0] mode,
    input wire logic [2:0] nd,
    input wire logic [15:0] pre,
    output logic link_clk,
    output logic devsel_n,
    output logic trdy_n,
    output logic stop_n
);
    // ****
    // Answers: 0 normal, 1 retry, 2 disconnect, 3 abort
    // ****
    int pend = 0;
    int n = 0;
    logic [1:0] m;
    always @(posedge mst_start) pend++;
    // Pins move with clock low; clock idles low between frames
    task tick(input logic [2:0] p);
        {devsel_n, trdy_n, stop_n} = p;
        #80 link_clk = 1;
        #80 link_clk = 0;
    endtask
    initial begin
        link_clk = 0;
        {devsel_n, trdy_n, stop_n} = 3'b111;
        forever begin
            wait (pend > 0);
            pend--;
            m = (n < pre) ? 2'h1 : mode;
            n++;
            #40;
            if (m == 2'h3) begin
                tick(3'b011);
                tick(3'b110);
            end else if (m == 2'h1) begin
                tick(3'b010);
            end else begin
                repeat (nd) tick(3'b001);
                if (m == 2'h2) tick(3'b010);
            end
            {devsel_n, trdy_n, stop_n} = 3'b111;
        end
    end
endmodule

//--- bench/bridge_termination_handler_test.sv
// Bench for bth_term: register bus, initiator requests, target model.
// Assumes bth_tgt_model answers and the checker is bound.
`timescale 1ns/1ns
module bridge_termination_handler_test import bth_pkg::*;;
    typedef struct packed {logic [1:0] k; logic [3:0] c; logic [7:0] d; logic pf, pri;
        logic [1:0] m; logic [2:0] nd; bth_resp_t e;} bth_case_t;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, link_clk, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, req_addr = 0, mst_addr, v;
    logic [1:0] htrans = 0, kind = 0, mode = 0;
    logic req_valid = 0, req_prefetch = 0, req_locked = 0, req_primary = 0, serr, seen = 0;
    logic pw_space_ok = 1, queue_full = 0, lock_crossing = 0, tbus_locked = 0;
    logic discarding = 0, posted_ahead = 0, init_resp_valid, mst_start;
    logic devsel_n, trdy_n, stop_n;
    logic [3:0] req_cmd = 0, mst_cmd;
    logic [7:0] req_dwords = 0, mst_dwords;
    logic [2:0] nd = 1;
    logic [15:0] pre = 0;
    logic [43:0] sq[$];
    bth_resp_t init_resp, r;
    int n_mismatch = 0, tests_run = 0, cyc = 0, i, b;
    logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h64, 8'h10};
    logic [31:0] rv[6] = '{0, 32'h0100_0000, 0, 0, 0, 0};
    logic [7:0] rf[5] = '{8'h30, 8'h40, 8'h58, 8'h94, 8'h13};
    logic [1:0] lk[3] = '{2'h0, 2'h2, 2'h1};
    logic [31:0] lm[3] = '{32'h04, 32'h20, 32'h20};
    logic le[3] = '{1, 0, 1};
    bth_case_t cs[7] = '{'{0, 7, 2, 0, 1, 0, 1, R_DATA_DISC}, '{2, 6, 2, 0, 1, 0, 1, R_DATA_DISC},
        '{2, 12, 4, 1, 1, 0, 4, R_DATA}, '{2, 12, 4, 1, 1, 2, 2, R_DATA_DISC},
        '{2, 12, 2, 1, 1, 2, 2, R_DATA}, '{2, 6, 1, 0, 1, 3, 1, R_ABORT},
        '{0, 7, 1, 0, 0, 3, 1, R_ABORT}};
    bth_term #(.MASTER_TIMEOUT(20)) i_bth_term (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .link_clk, .tgt_devsel_n(devsel_n), .tgt_trdy_n(trdy_n), .tgt_stop_n(stop_n),
        .req_valid, .req_kind(bth_kind_t'(kind)), .req_cmd, .req_addr, .req_dwords,
        .req_prefetch, .req_locked, .req_primary, .pw_space_ok, .queue_full, .lock_crossing,
        .tbus_locked, .discarding, .posted_ahead, .init_resp_valid, .init_resp, .mst_start,
        .mst_addr, .mst_cmd, .mst_dwords, .primary_system_error_out(serr));
    bth_tgt_model i_bth_tgt_model (.mst_start, .mode, .nd, .pre, .link_clk, .devsel_n,
        .trdy_n, .stop_n);
    // ****
    // Tasks
    // ****
    initial forever #5 hclk = ~hclk;
    task end_of_test;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input string n, input logic [43:0] g, input logic [43:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk iff hreadyout === 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk iff hreadyout === 1'b1);
        q = hrdata;
    endtask
    task ask;
        @(posedge hclk);
        req_valid <= 1;
        @(posedge hclk);
        req_valid <= 0;
        #1 r = init_resp;
        chk("answer", init_resp_valid, 1);
    endtask
    // Repeats stay under the master timeout
    task fin;
        for (int j = 0; j < 40; j++) begin
            repeat (8) @(posedge hclk);
            ask;
            if (r !== R_RETRY) break;
        end
    endtask
    task waitq(input int k);
        for (int j = 0; j < 600 && sq.size() < k; j++) @(posedge hclk);
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (mst_start === 1'b1) sq.push_back({mst_cmd, mst_dwords, mst_addr});
        if (serr === 1'b1) seen <= 1;
        if (cyc == 10000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    // ****
    // Sequence
    // ****
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1;
        for (i = 0; i < 6; i++) begin
            bus(0, ra[i], 0, v);
            chk("reset", {hresp, v}, {1'b0, rv[i]});
        end
        bus(1, 8'h04, 3, v);
        bus(1, 8'h00, 32'h100, v);
        bus(1, 8'h64, 32'h24, v);
        bus(0, 8'h64, 0, v);
        chk("mask", v, 32'h24);
        for (i = 0; i < 5; i++) begin
            @(posedge hclk);
            {kind, queue_full, pw_space_ok, lock_crossing, discarding, tbus_locked,
                req_locked} <= rf[i];
            ask;
            chk("refuse", r, R_RETRY);
        end
        @(posedge hclk);
        {queue_full, pw_space_ok, lock_crossing, discarding, tbus_locked, req_locked} <= 6'h10;
        for (i = 0; i < 7; i++) begin
            repeat (40) @(posedge hclk);
            {kind, req_cmd, req_dwords, req_prefetch, req_primary, mode, nd} <= cs[i][23:3];
            req_addr <= 32'h1000 + 32'(i * 16);
            pre <= 16'(sq.size() + 1);
            ask;
            chk("queue", r, R_RETRY);
            fin;
            chk("final", r, cs[i].e);
            chk("addr", sq[$][31:0], 32'h1000 + 32'(i * 16));
        end
        bus(0, 8'h08, 0, v);
        chk("status", v, 32'hf);
        bus(1, 8'h08, 32'hf, v);
        bus(0, 8'h08, 0, v);
        chk("clear", v, 0);
        b = sq.size();
        {kind, req_cmd, req_dwords, req_prefetch, req_primary, mode, nd} <= cs[1][23:3];
        pre <= 0;
        ask;
        repeat (100) @(posedge hclk);
        ask;
        chk("dropped", r, R_RETRY);
        waitq(b + 2);
        chk("requeue", sq.size(), b + 2);
        repeat (100) @(posedge hclk);
        kind <= 2'h1;
        {req_cmd, req_dwords, req_addr, mode, nd} <= {4'hf, 8'h4, 32'h2000, 2'h2, 3'h2};
        pre <= 16'(sq.size() + 1);
        b = sq.size();
        ask;
        waitq(b + 3);
        repeat (60) @(posedge hclk);
        chk("retry", sq[b + 1], {4'hf, 8'h4, 32'h2000});
        chk("resume", sq[b + 2], {4'h7, 8'h2, 32'h2008});
        chk("starts", sq.size(), b + 3);
        mode <= 2'h3;
        ask;
        repeat (150) @(posedge hclk);
        chk("serr", seen, 1);
        bus(0, 8'h08, 0, v);
        chk("status", v, 32'h18);
        seen <= 0;
        for (i = 0; i < 3; i++) begin
            bus(1, 8'h64, lm[i], v);
            kind <= lk[i];
            pre <= 16'hffff;
            b = sq.size();
            ask;
            repeat (250) @(posedge hclk);
            chk("limit", seen, le[i]);
            chk("tries", sq.size(), b + 3);
            seen <= 0;
        end
        end_of_test;
    end
endmodule
